// File: spcsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_top (
	input wire logic ref_clk, // core clock
	input wire logic reset, // sync reset, active high
	input wire spcsm_pkg::spcsm_bus_t bus, // register port request
	output logic [spcsm_pkg::DW-1:0] rd_data_q, // read data
	input wire spcsm_pkg::spcsm_xlat_t xlat, // translation lookup
	output logic xlat_fill_q, // translation may be cached
	output logic xlat_fault_q, // page fault
	input wire logic [spcsm_pkg::NLP-1:0] lp_active, // in an enclave
	input wire logic [spcsm_pkg::NLP-1:0][spcsm_pkg::PW-1:0] lp_encl,
	// enclave of each processor
	input wire logic [spcsm_pkg::NLP-1:0] ipi, // interrupt pulse
	output logic [spcsm_pkg::NLP-1:0] lp_flush_q, // exit and flush
	output logic wb_valid_q, // ciphertext writeback pulse
	output logic [spcsm_pkg::PW-1:0] wb_page_q, // evicted page
	output logic [spcsm_pkg::TW-1:0] wb_tag_q, // tag for metadata
	output logic zero_fill_q, // clear page contents pulse
	output logic [spcsm_pkg::PW-1:0] zero_page_q // page to clear
);
	import spcsm_pkg::*;

	// ****************************************************
	// state
	// ****************************************************
	spcsm_state_t state_q;
	spcsm_cmd_t cmd_q;
	spcsm_err_t err_q;
	spcsm_err_t chk_err;
	spcsm_page_t tbl_q [NPG];
	spcsm_page_t pg;
	spcsm_page_t sp;
	spcsm_page_t par;
	spcsm_slot_t sd;
	spcsm_slot_t mem_wdata;
	logic [SAW-1:0] mem_waddr;
	logic mem_we;
	logic [NLP-1:0] mask_q;
	logic [NLP-1:0] mask_d;
	logic [NLP-1:0] mask_new;
	logic [TW-1:0] rtag_q;
	logic [TW-1:0] meta_tag_q;
	logic [VW-1:0] ver_q;
	logic [VW-1:0] meta_ver_q;
	logic [1:0] meta_typ_q;
	logic [PW-1:0] meta_own_q;
	logic [PW-1:0] psel_q;
	logic [SW-1:0] init_ix_q;
	logic [TW-1:0] ld_tag;
	logic cmd_take;
	logic chk_ok;
	logic children;

	function automatic logic owned_resident(
		input spcsm_page_t t [NPG],
		input logic [PW-1:0] ctl
	);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NPG; i++) begin
			if (t[i].valid && t[i].owner == ctl &&
			    t[i].ptype != control_page_type &&
			    t[i].ptype != version_array_type) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	// ****************************************************
	// register port
	// ****************************************************
	// a command written while busy is dropped
	assign cmd_take = bus.wr && bus.addr == ADDR_CMD && state_q == ST_IDLE;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmd_q <= '0;
		end else if (cmd_take) begin
			cmd_q.op <= bus.wdata[CMD_OP_LSB +: 4];
			cmd_q.page <= bus.wdata[CMD_PG_LSB +: PW];
			cmd_q.slot_pg <= bus.wdata[CMD_SPG_LSB +: PW];
			cmd_q.slot_ix <= bus.wdata[CMD_SIX_LSB +: SW];
			cmd_q.ptype <= bus.wdata[CMD_TYP_LSB +: 2];
			cmd_q.owner <= bus.wdata[CMD_OWN_LSB +: PW];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rtag_q <= '0;
			psel_q <= '0;
		end else if (bus.wr && bus.addr == ADDR_RTAG) begin
			rtag_q <= bus.wdata[TW-1:0];
		end else if (bus.wr && bus.addr == ADDR_PSEL) begin
			psel_q <= bus.wdata[PW-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= '0;
			if (bus.rd) begin
				case (bus.addr)
					ADDR_RTAG: rd_data_q[TW-1:0] <= rtag_q;
					ADDR_STAT: begin
						rd_data_q[STAT_BUSY_BIT] <= state_q != ST_IDLE;
						rd_data_q[STAT_ERR_LSB +: 4] <= err_q;
						rd_data_q[STAT_MASK_LSB +: NLP] <= mask_q;
					end
					ADDR_META: begin
						rd_data_q[META_TAG_LSB +: TW] <= meta_tag_q;
						rd_data_q[META_VER_LSB +: VW] <= meta_ver_q;
						rd_data_q[META_TYP_LSB +: 2] <= meta_typ_q;
						rd_data_q[META_OWN_LSB +: PW] <= meta_own_q;
					end
					ADDR_PST: rd_data_q[$bits(spcsm_page_t)-1:0] <= tbl_q[psel_q];
					default: rd_data_q <= '0;
				endcase
			end
		end
	end

	// ****************************************************
	// sequencer
	// ****************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			init_ix_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: if (cmd_take) begin
					state_q <= ST_RD;
				end
				ST_RD: state_q <= ST_CHK;
				ST_CHK: begin
					init_ix_q <= '0;
					if (chk_ok && cmd_q.op == OP_ADDVA) begin
						state_q <= ST_INIT;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				ST_INIT: begin
					init_ix_q <= init_ix_q + 1'b1;
					if (init_ix_q == SLOT_LAST) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************
	// command checks
	// ****************************************************
	assign pg = tbl_q[cmd_q.page];
	assign sp = tbl_q[cmd_q.slot_pg];
	assign par = tbl_q[cmd_q.owner];
	assign children = owned_resident(tbl_q, cmd_q.page);
	assign ld_tag = spcsm_mac(cmd_q.page, sd.ver, cmd_q.ptype, cmd_q.owner);

	always_comb begin
		chk_err = ERR_NONE;
		case (cmd_q.op)
			OP_BLOCK: if (!pg.valid || pg.blocked ||
			    pg.ptype != regular_page_type) begin
				chk_err = ERR_STATE;
			end
			OP_TRACK: if (!pg.valid || pg.ptype != control_page_type) begin
				chk_err = ERR_STATE;
			end
			OP_EVICT: begin
				if (!pg.valid) begin
					chk_err = ERR_STATE;
				end else if (cmd_q.slot_pg == cmd_q.page) begin
					chk_err = ERR_SLOT;
				end else if (!sp.valid || sp.ptype != version_array_type ||
				    sd.full) begin
					chk_err = ERR_SLOT;
				end else if (pg.ptype == control_page_type && children) begin
					chk_err = ERR_RESIDENT;
				end else if (pg.ptype == regular_page_type &&
				    (!pg.blocked || !pg.tracked || mask_q != '0)) begin
					chk_err = ERR_TRACK;
				end
			end
			OP_LDU, OP_LDB: begin
				if (pg.valid) begin
					chk_err = ERR_STATE;
				end else if (!sp.valid || sp.ptype != version_array_type ||
				    !sd.full) begin
					chk_err = ERR_SLOT;
				end else if (cmd_q.ptype == regular_page_type &&
				    (!par.valid || par.ptype != control_page_type)) begin
					chk_err = ERR_STATE;
				end else if (ld_tag != rtag_q) begin
					chk_err = ERR_TAG;
				end
			end
			OP_ADDVA: if (pg.valid) begin
				chk_err = ERR_STATE;
			end
			OP_AUG: if (pg.valid || !par.valid ||
			    par.ptype != control_page_type) begin
				chk_err = ERR_STATE;
			end
			OP_ACC: if (!pg.valid || !pg.pending ||
			    pg.ptype != regular_page_type) begin
				chk_err = ERR_STATE;
			end
			default: chk_err = ERR_OPCODE;
		endcase
	end

	assign chk_ok = state_q == ST_CHK && chk_err == ERR_NONE;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			err_q <= ERR_NONE;
		end else if (state_q == ST_CHK) begin
			err_q <= chk_err;
		end
	end

	// ****************************************************
	// page table
	// ****************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < NPG; i++) begin
				tbl_q[i] <= '0;
			end
		end else if (chk_ok) begin
			case (cmd_q.op)
				OP_BLOCK: begin
					tbl_q[cmd_q.page].blocked <= 1'b1;
					tbl_q[cmd_q.page].tracked <= 1'b0;
				end
				OP_TRACK: begin
					for (int i = 0; i < NPG; i++) begin
						if (tbl_q[i].valid && tbl_q[i].blocked &&
						    tbl_q[i].owner == cmd_q.page) begin
							tbl_q[i].tracked <= 1'b1;
						end
					end
				end
				OP_EVICT: tbl_q[cmd_q.page] <= '0;
				OP_LDU, OP_LDB: begin
					tbl_q[cmd_q.page].valid <= 1'b1;
					tbl_q[cmd_q.page].blocked <= cmd_q.op == OP_LDB;
					tbl_q[cmd_q.page].pending <= 1'b0;
					tbl_q[cmd_q.page].tracked <= 1'b0;
					tbl_q[cmd_q.page].ptype <= cmd_q.ptype;
					tbl_q[cmd_q.page].owner <= cmd_q.owner;
				end
				OP_ADDVA: begin
					tbl_q[cmd_q.page].valid <= 1'b1;
					tbl_q[cmd_q.page].ptype <= version_array_type;
					tbl_q[cmd_q.page].owner <= cmd_q.page;
				end
				OP_AUG: begin
					tbl_q[cmd_q.page].valid <= 1'b1;
					tbl_q[cmd_q.page].pending <= 1'b1;
					tbl_q[cmd_q.page].blocked <= 1'b0;
					tbl_q[cmd_q.page].tracked <= 1'b0;
					tbl_q[cmd_q.page].ptype <= regular_page_type;
					tbl_q[cmd_q.page].owner <= cmd_q.owner;
				end
				OP_ACC: tbl_q[cmd_q.page].pending <= 1'b0;
				default: tbl_q[cmd_q.page] <= tbl_q[cmd_q.page];
			endcase
		end
	end

	// ****************************************************
	// version slots
	// ****************************************************
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = {cmd_q.slot_pg, cmd_q.slot_ix};
		mem_wdata = '0;
		if (state_q == ST_INIT) begin
			mem_we = 1'b1;
			mem_waddr = {cmd_q.page, init_ix_q};
		end else if (chk_ok && cmd_q.op == OP_EVICT) begin
			mem_we = 1'b1;
			mem_wdata = '{full: 1'b1, ver: ver_q};
		end else if (chk_ok && (cmd_q.op == OP_LDU || cmd_q.op == OP_LDB)) begin
			mem_we = 1'b1;
		end
	end

	spcsm_slot_mem u_slots (
		.ref_clk(ref_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr({cmd_q.slot_pg, cmd_q.slot_ix}),
		.rdata_q(sd)
	);

	// ****************************************************
	// eviction output and metadata
	// ****************************************************
	// version is one running count shared by all slots; wrap only risks a stale
	// copy after 256 evictions in total
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ver_q <= VER_ONE;
			meta_tag_q <= '0;
			meta_ver_q <= '0;
			meta_typ_q <= '0;
			meta_own_q <= '0;
			wb_valid_q <= 1'b0;
			wb_page_q <= '0;
			wb_tag_q <= '0;
		end else begin
			wb_valid_q <= 1'b0;
			if (chk_ok && cmd_q.op == OP_EVICT) begin
				ver_q <= ver_q + VER_ONE;
				meta_tag_q <= spcsm_mac(cmd_q.page, ver_q, pg.ptype,
					pg.owner);
				meta_ver_q <= ver_q;
				meta_typ_q <= pg.ptype;
				meta_own_q <= pg.owner;
				wb_valid_q <= 1'b1;
				wb_page_q <= cmd_q.page;
				wb_tag_q <= spcsm_mac(cmd_q.page, ver_q, pg.ptype,
					pg.owner);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			zero_fill_q <= 1'b0;
			zero_page_q <= '0;
		end else begin
			zero_fill_q <= chk_ok && cmd_q.op == OP_AUG;
			if (chk_ok && cmd_q.op == OP_AUG) begin
				zero_page_q <= cmd_q.page;
			end
		end
	end

	// ****************************************************
	// tracking
	// ****************************************************
	// snapshot of processors inside the enclave; a later re-entry is
	// not added, it can only hold fresh translations
	always_comb begin
		mask_new = '0;
		if (chk_ok && cmd_q.op == OP_TRACK) begin
			for (int i = 0; i < NLP; i++) begin
				mask_new[i] = lp_active[i] && lp_encl[i] == cmd_q.page;
			end
		end
		mask_d = (mask_q | mask_new) & lp_active & ~ipi;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mask_q <= '0;
			lp_flush_q <= '0;
		end else begin
			mask_q <= mask_d;
			lp_flush_q <= ipi;
		end
	end

	// ****************************************************
	// translation lookups
	// ****************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			xlat_fill_q <= 1'b0;
			xlat_fault_q <= 1'b0;
		end else begin
			xlat_fill_q <= xlat.req && !xlat.hit &&
				tbl_q[xlat.page].valid && !tbl_q[xlat.page].blocked &&
				!tbl_q[xlat.page].pending;
			xlat_fault_q <= xlat.req && !xlat.hit &&
				(!tbl_q[xlat.page].valid || tbl_q[xlat.page].blocked ||
				tbl_q[xlat.page].pending);
		end
	end
endmodule // spcsm_top
`default_nettype wire

// File: spcsm_pkg.sv
`default_nettype none
package spcsm_pkg;
	// ****************************************************
	// sizes
	// ****************************************************
	localparam int NPG = 16;
	localparam int PW = 4;
	localparam int NSLOT = 4;
	localparam int SW = 2;
	localparam int SAW = PW + SW;
	localparam int NLP = 4;
	localparam int VW = 8;
	localparam int TW = 16;
	localparam int AW = 8;
	localparam int DW = 32;

	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [AW-1:0] ADDR_CMD = 8'h00;
	localparam logic [AW-1:0] ADDR_RTAG = 8'h04;
	localparam logic [AW-1:0] ADDR_STAT = 8'h08;
	localparam logic [AW-1:0] ADDR_META = 8'h0C;
	localparam logic [AW-1:0] ADDR_PSEL = 8'h10;
	localparam logic [AW-1:0] ADDR_PST = 8'h14;

	localparam int CMD_OP_LSB = 0;
	localparam int CMD_PG_LSB = 4;
	localparam int CMD_SPG_LSB = 8;
	localparam int CMD_SIX_LSB = 12;
	localparam int CMD_TYP_LSB = 16;
	localparam int CMD_OWN_LSB = 20;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_LSB = 4;
	localparam int STAT_MASK_LSB = 8;
	localparam int META_TAG_LSB = 0;
	localparam int META_VER_LSB = 16;
	localparam int META_TYP_LSB = 24;
	localparam int META_OWN_LSB = 28;

	// arbitrary value, stands in for the device key
	localparam logic [TW-1:0] TAG_KEY = 16'h5A3C;
	localparam logic [VW-1:0] VER_ONE = 8'h01;
	localparam logic [SW-1:0] SLOT_LAST = 2'h3;

	// ****************************************************
	// types
	// ****************************************************
	typedef enum logic [3:0] {
		OP_BLOCK = 4'h1, OP_TRACK = 4'h2, OP_EVICT = 4'h3,
		OP_LDU = 4'h4, OP_LDB = 4'h5, OP_ADDVA = 4'h6,
		OP_AUG = 4'h7, OP_ACC = 4'h8
	} spcsm_op_t;

	typedef enum logic [1:0] {
		regular_page_type = 2'h0,
		control_page_type = 2'h1,
		version_array_type = 2'h2
	} spcsm_ptype_t;

	typedef enum logic [3:0] {
		ERR_NONE = 4'h0, ERR_STATE = 4'h1, ERR_SLOT = 4'h2,
		ERR_TAG = 4'h3, ERR_RESIDENT = 4'h4, ERR_TRACK = 4'h5,
		ERR_OPCODE = 4'h6
	} spcsm_err_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001, ST_RD = 4'b0010,
		ST_CHK = 4'b0100, ST_INIT = 4'b1000
	} spcsm_state_t;

	typedef struct packed {
		logic valid;
		logic blocked;
		logic pending;
		logic tracked;
		logic [1:0] ptype;
		logic [PW-1:0] owner;
	} spcsm_page_t;

	typedef struct packed {
		logic full;
		logic [VW-1:0] ver;
	} spcsm_slot_t;

	typedef struct packed {
		logic [3:0] op;
		logic [PW-1:0] page;
		logic [PW-1:0] slot_pg;
		logic [SW-1:0] slot_ix;
		logic [1:0] ptype;
		logic [PW-1:0] owner;
	} spcsm_cmd_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} spcsm_bus_t;

	typedef struct packed {
		logic req;
		logic hit;
		logic [PW-1:0] page;
	} spcsm_xlat_t;

	// integrity tag over page identity, version and metadata
	function automatic logic [TW-1:0] spcsm_mac(
		input logic [PW-1:0] page,
		input logic [VW-1:0] ver,
		input logic [1:0] ptype,
		input logic [PW-1:0] owner
	);
		logic [TW-1:0] x;
		x = TAG_KEY ^ {ver, owner, ptype, 2'h0} ^ {page, 12'h000};
		return {x[10:0], x[15:11]} ^ {ver, ver};
	endfunction
endpackage
`default_nettype wire

// File: spcsm_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
// version slot store, registered read
module spcsm_slot_mem (
	input wire logic ref_clk, // core clock
	input wire logic we, // write enable
	input wire logic [spcsm_pkg::SAW-1:0] waddr, // write slot
	input wire spcsm_pkg::spcsm_slot_t wdata, // write data
	input wire logic [spcsm_pkg::SAW-1:0] raddr, // read slot
	output spcsm_pkg::spcsm_slot_t rdata_q // read data, next cycle
);
	import spcsm_pkg::*;

	spcsm_slot_t mem [NPG*NSLOT];

	// no reset: a slot page made by OP_ADDVA is cleared before use; one loaded as a version array is not
	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		rdata_q <= mem[raddr];
	end
endmodule // spcsm_slot_mem
`default_nettype wire

// File: spcsm_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spcsm_top_chk (
	input wire logic ref_clk, // core clock
	input wire logic reset, // sync reset
	input wire spcsm_pkg::spcsm_bus_t bus, // register request
	input wire spcsm_pkg::spcsm_xlat_t xlat, // lookup request
	input wire logic xlat_fill_q, // may cache
	input wire logic xlat_fault_q, // page fault
	input wire logic [spcsm_pkg::NLP-1:0] ipi, // interrupts
	input wire logic [spcsm_pkg::NLP-1:0] lp_flush_q, // flushes
	input wire logic wb_valid_q, // writeback pulse
	input wire logic [spcsm_pkg::PW-1:0] wb_page_q, // evicted page
	input wire logic [spcsm_pkg::TW-1:0] wb_tag_q, // evict tag
	input wire logic zero_fill_q, // clear pulse
	input wire logic [spcsm_pkg::PW-1:0] zero_page_q // cleared page
);
	import spcsm_pkg::*;
	// *****
	// properties
	// *****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_miss;
		xlat.req && !xlat.hit;
	endsequence
	sequence s_hit;
		xlat.req && xlat.hit;
	endsequence
	sequence s_one_shot;
		wb_valid_q ##1 !wb_valid_q;
	endsequence
	a_fill_cause: assert property (xlat_fill_q |->
		$past(xlat.req && !xlat.hit))
		else $error("fill without a missed lookup");
	a_fault_cause: assert property (xlat_fault_q |->
		$past(xlat.req && !xlat.hit))
		else $error("fault without a missed lookup");
	a_miss_answers: assert property (s_miss |=>
		xlat_fill_q ^ xlat_fault_q)
		else $error("missed lookup not answered once");
	a_hit_quiet: assert property (s_hit |=>
		!xlat_fill_q && !xlat_fault_q)
		else $error("cached lookup answered");
	a_flush_follow: assert property (lp_flush_q == $past(ipi))
		else $error("flush does not follow interrupt");
	a_wb_source: assert property (wb_valid_q |->
		$past(bus.wr && bus.addr == ADDR_CMD &&
		bus.wdata[3:0] == OP_EVICT, 3))
		else $error("writeback without evict command");
	a_wb_single: assert property (wb_valid_q |-> s_one_shot)
		else $error("writeback longer than one cycle");
	a_wb_held: assert property ($changed(wb_page_q) ||
		$changed(wb_tag_q) |-> wb_valid_q)
		else $error("writeback fields moved without pulse");
	a_zero_source: assert property (zero_fill_q |->
		$past(bus.wr && bus.addr == ADDR_CMD &&
		bus.wdata[3:0] == OP_AUG, 3))
		else $error("clear without augment command");
	a_zero_held: assert property ($changed(zero_page_q) |-> zero_fill_q)
		else $error("clear page moved without pulse");
endmodule // spcsm_top_chk
`default_nettype wire

// File: spcsm_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
// logical processors: enter on request, leave on flush
module spcsm_lp_model (
	input wire logic ref_clk, // core clock
	input wire logic reset, // sync reset
	input wire logic [spcsm_pkg::NLP-1:0] enter, // enter pulses
	input wire logic [spcsm_pkg::PW-1:0] encl, // enclave to enter
	input wire logic [spcsm_pkg::NLP-1:0] lp_flush_q, // exit and flush
	output logic [spcsm_pkg::NLP-1:0] lp_active, // inside enclave
	output logic [spcsm_pkg::NLP-1:0][spcsm_pkg::PW-1:0] lp_encl // enclave
);
	import spcsm_pkg::*;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lp_active <= '0;
		end else begin
			lp_active <= (lp_active & ~lp_flush_q) | enter;
		end
	end
	// idle processors show junk, not a stale enclave
	always_comb begin
		for (int i = 0; i < NLP; i++) begin
			lp_encl[i] = lp_active[i] ? encl : ~encl;
		end
	end
endmodule // spcsm_lp_model
`default_nettype wire

// File: secure_page_cache_state_manager_test.sv
`timescale 1ns/1ps
`default_nettype none
module secure_page_cache_state_manager_test;
	import spcsm_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	spcsm_bus_t bus = '0;
	spcsm_xlat_t xlat = '0;
	logic [NLP-1:0] ipi = '0;
	logic [NLP-1:0] enter = '0;
	logic [PW-1:0] encl = 4'h3;
	logic [DW-1:0] rd_data_q, d;
	logic xlat_fill_q, xlat_fault_q, wb_valid_q, zero_fill_q, h;
	logic [NLP-1:0] lp_active, lp_flush_q;
	logic [NLP-1:0][PW-1:0] lp_encl;
	logic [PW-1:0] wb_page_q, zero_page_q, pg;
	logic [TW-1:0] wb_tag_q, t3, t5, tf;
	logic [3:0] op;
	int n_errors = 0, cmp_count = 0, cycles = 0, n_wb = 0, n_zf = 0;
	always #4 ref_clk = ~ref_clk;
	spcsm_top dut_u (.ref_clk(ref_clk), .reset(reset), .bus(bus),
		.rd_data_q(rd_data_q), .xlat(xlat), .xlat_fill_q(xlat_fill_q),
		.xlat_fault_q(xlat_fault_q), .lp_active(lp_active),
		.lp_encl(lp_encl), .ipi(ipi), .lp_flush_q(lp_flush_q),
		.wb_valid_q(wb_valid_q), .wb_page_q(wb_page_q),
		.wb_tag_q(wb_tag_q), .zero_fill_q(zero_fill_q),
		.zero_page_q(zero_page_q));
	spcsm_lp_model lp_u (.ref_clk(ref_clk), .reset(reset), .enter(enter),
		.encl(encl), .lp_flush_q(lp_flush_q), .lp_active(lp_active),
		.lp_encl(lp_encl));
	// *****
	// helpers
	// *****
	function automatic logic [31:0] cw(logic [3:0] o, logic [3:0] p,
		logic [3:0] sp, logic [1:0] sx, logic [1:0] ty, logic [3:0] ow);
		return {8'h00, ow, 2'h0, ty, 2'h0, sx, sp, p, o};
	endfunction
	function automatic logic [15:0] tagf(logic [3:0] p, logic [7:0] v,
		logic [1:0] ty, logic [3:0] o);
		logic [15:0] x;
		x = TAG_KEY ^ {v, o, ty, 2'h0} ^ {p, 12'h000};
		return {x[10:0], x[15:11]} ^ {v, v};
	endfunction
	function automatic logic [31:0] pe(logic [3:0] f, logic [1:0] ty,
		logic [3:0] o);
		return {22'h000000, f, ty, o};
	endfunction
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_err(input logic [3:0] e, input logic [3:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected status: expected %h seen %h", e, g);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge ref_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge ref_clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge ref_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
		@(posedge ref_clk);
		bus <= '0;
		#1 v = rd_data_q;
	endtask
	// poll busy with a bound, then compare the status code
	task automatic cmd(input logic [31:0] w, input logic [3:0] e);
		logic [DW-1:0] s;
		s = 32'h00000001;
		wr(ADDR_CMD, w);
		for (int i = 0; i < 20 && s[0] !== 1'b0; i++) rd(ADDR_STAT, s);
		// a command still busy after the poll limit is a hang
		chk_word("busy", 32'h0, {31'h0, s[STAT_BUSY_BIT]});
		chk_err(e, s[7:4]);
	endtask
	task automatic page_is(input logic [3:0] p, input logic [31:0] m,
		input logic [31:0] e);
		wr(ADDR_PSEL, {28'h0000000, p});
		rd(ADDR_PST, d);
		chk_word("page entry", e, d & m);
	endtask
	task automatic look(input logic [3:0] p, input logic ht,
		input logic [1:0] e);
		@(posedge ref_clk);
		xlat <= '{req: 1'b1, hit: ht, page: p};
		@(posedge ref_clk);
		xlat <= '0;
		#1 chk_word("fill fault", {30'h0, e},
			{30'h0, xlat_fill_q, xlat_fault_q});
	endtask
	task automatic enter_lp();
		@(posedge ref_clk);
		enter <= 4'h1;
		@(posedge ref_clk);
		enter <= '0;
	endtask
	always @(posedge ref_clk) begin
		if (!reset) begin
			n_wb += int'(wb_valid_q === 1'b1);
			n_zf += int'(zero_fill_q === 1'b1);
		end
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	// *****
	// sequence
	// *****
	initial begin
		d = $urandom(32'h3c4e7d77);
		t3 = tagf(4'h3, VER_ONE, 2'h1, 4'h3);
		t5 = tagf(4'h5, 8'h02, 2'h0, 4'h3);
		tf = tagf(4'hF, VER_ONE, 2'h2, 4'hF);
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		cmd(cw(4'h0, 4'h0, 4'h0, 2'h0, 2'h0, 4'h0), ERR_OPCODE);
		repeat (6) begin
			op = 4'h9 + 4'($urandom % 7);
			pg = 4'($urandom);
			cmd(cw(op, pg, 4'h0, 2'h0, 2'h0, 4'h0), ERR_OPCODE);
		end
		cmd(cw(OP_ADDVA, 4'hE, 4'h0, 2'h0, 2'h2, 4'hE), ERR_NONE);
		cmd(cw(OP_ADDVA, 4'hF, 4'h0, 2'h0, 2'h2, 4'hF), ERR_NONE);
		page_is(4'hE, 32'h3FF, pe(4'h8, 2'h2, 4'hE));
		cmd(cw(OP_EVICT, 4'hF, 4'hF, 2'h0, 2'h2, 4'hF), ERR_SLOT);
		page_is(4'hF, 32'h3FF, pe(4'h8, 2'h2, 4'hF));
		cmd(cw(OP_EVICT, 4'hF, 4'hE, 2'h0, 2'h2, 4'hF), ERR_NONE);
		chk_word("wb count", 32'h1, 32'(n_wb));
		chk_word("wb page", 32'hF, {28'h0, wb_page_q});
		chk_word("wb tag", {16'h0, tf}, {16'h0, wb_tag_q});
		rd(ADDR_META, d);
		chk_word("meta", {4'hF, 2'h0, 2'h2, VER_ONE, tf}, d);
		page_is(4'hF, 32'h200, 32'h0);
		wr(ADDR_RTAG, {16'h0, ~t3});
		cmd(cw(OP_LDU, 4'h3, 4'hE, 2'h0, 2'h1, 4'h3), ERR_TAG);
		page_is(4'h3, 32'h200, 32'h0);
		wr(ADDR_RTAG, {16'h0, t3});
		cmd(cw(OP_LDU, 4'h3, 4'hE, 2'h0, 2'h1, 4'h3), ERR_NONE);
		page_is(4'h3, 32'h3FF, pe(4'h8, 2'h1, 4'h3));
		cmd(cw(OP_LDU, 4'h4, 4'hE, 2'h0, 2'h1, 4'h4), ERR_SLOT);
		cmd(cw(OP_AUG, 4'h3, 4'h0, 2'h0, 2'h0, 4'h3), ERR_STATE);
		cmd(cw(OP_AUG, 4'h5, 4'h0, 2'h0, 2'h0, 4'h3), ERR_NONE);
		chk_word("zero page", 32'h5, {28'h0, zero_page_q});
		chk_word("zero count", 32'h1, 32'(n_zf));
		page_is(4'h5, 32'h3FF, pe(4'hA, 2'h0, 4'h3));
		look(4'h5, 1'b0, 2'b01);
		cmd(cw(OP_ACC, 4'h5, 4'h0, 2'h0, 2'h0, 4'h3), ERR_NONE);
		page_is(4'h5, 32'h3FF, pe(4'h8, 2'h0, 4'h3));
		cmd(cw(OP_ACC, 4'h5, 4'h0, 2'h0, 2'h0, 4'h3), ERR_STATE);
		look(4'h5, 1'b0, 2'b10);
		cmd(cw(OP_EVICT, 4'h3, 4'hE, 2'h1, 2'h1, 4'h3), ERR_RESIDENT);
		cmd(cw(OP_EVICT, 4'h5, 4'hE, 2'h1, 2'h0, 4'h3), ERR_TRACK);
		cmd(cw(OP_BLOCK, 4'h5, 4'h0, 2'h0, 2'h0, 4'h3), ERR_NONE);
		page_is(4'h5, 32'h100, 32'h100);
		look(4'h5, 1'b0, 2'b01);
		look(4'h5, 1'b1, 2'b00);
		enter_lp();
		cmd(cw(OP_EVICT, 4'h5, 4'hE, 2'h1, 2'h0, 4'h3), ERR_TRACK);
		cmd(cw(OP_TRACK, 4'h3, 4'h0, 2'h0, 2'h0, 4'h3), ERR_NONE);
		rd(ADDR_STAT, d);
		chk_word("mask", 32'h1, {28'h0, d[11:8]});
		cmd(cw(OP_EVICT, 4'h5, 4'hE, 2'h1, 2'h0, 4'h3), ERR_TRACK);
		@(posedge ref_clk);
		ipi <= 4'h1;
		@(posedge ref_clk);
		ipi <= '0;
		#1 chk_word("flush", 32'h1, {28'h0, lp_flush_q});
		enter_lp();
		rd(ADDR_STAT, d);
		chk_word("mask", 32'h0, {28'h0, d[11:8]});
		cmd(cw(OP_EVICT, 4'h5, 4'hE, 2'h1, 2'h0, 4'h3), ERR_NONE);
		chk_word("wb page", 32'h5, {28'h0, wb_page_q});
		chk_word("wb tag", {16'h0, t5}, {16'h0, wb_tag_q});
		wr(ADDR_RTAG, {16'h0, t5});
		cmd(cw(OP_LDB, 4'h5, 4'hE, 2'h1, 2'h0, 4'h3), ERR_NONE);
		page_is(4'h5, 32'h3BF, pe(4'hC, 2'h0, 4'h3));
		repeat (8) begin
			pg = 4'h6 + 4'($urandom % 8);
			h = 1'($urandom);
			look(pg, h, h ? 2'b00 : 2'b01);
		end
		end_of_test();
	end
endmodule // secure_page_cache_state_manager_test
bind spcsm_top spcsm_top_chk chk_u (.ref_clk(ref_clk), .reset(reset),
	.bus(bus), .xlat(xlat), .xlat_fill_q(xlat_fill_q),
	.xlat_fault_q(xlat_fault_q), .ipi(ipi), .lp_flush_q(lp_flush_q),
	.wb_valid_q(wb_valid_q), .wb_page_q(wb_page_q), .wb_tag_q(wb_tag_q),
	.zero_fill_q(zero_fill_q), .zero_page_q(zero_page_q));
`default_nettype wire
